// *** src/column_driver_input_loader.sv ***
// twelve-channel column driver input loader with apb control
// Operation
// - strobe valid only if high at rising edge
// - next rising edge transfers latches, restarts loading
// - sequence fills twelve channel latches in order, one or two at a time
// - dual bus captures both buses on rising edges
// - direction select never changes dual bus edge
// - single bus, left: even rising, odd falling
// - single bus, right: even falling, odd rising
// - left fills 0 up; right fills 11 down
// - first bus even channels, second bus odd
// - thermal protection follows its enable bit
// - ground force low drives all outputs grounded
// - no alternation: polarity sets all output sides
// - alternation: even and odd sides oppose
// - output offset scales with full code minus code
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
module column_driver_input_loader
    import loader_pkg::*;
(
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic [11:0]                paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // pixel link pins from the timing controller
    input  wire logic                       pixel_clk,
    input  wire logic                       transfer_start_strobe,
    input  wire logic [WORD_W-1:0]          even_channel_bus,
    input  wire logic [WORD_W-1:0]          odd_channel_bus,
    // output stage
    output logic      [NUM_CH*WORD_W-1:0]   analog_channel_out,
    output logic      [NUM_CH*WORD_W-1:0]   channel_offset,
    output logic      [NUM_CH-1:0]          above_center,
    output logic                            outputs_grounded,
    output logic                            thermal_protect_on
);
    word_fifo_if #(.W(ENTRY_W), .CW(CNT_W)) q ();

    word_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .q       (q)
    );

    // pin synchronisers; third stage gives the level before the edge
    logic [2:0]        clk_s;
    logic [2:0]        xfr_s;
    logic [WORD_W-1:0] evn_s [3];
    logic [WORD_W-1:0] odd_s [3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_s <= '0;
            xfr_s <= '0;
            evn_s <= '{default: '0};
            odd_s <= '{default: '0};
        end else begin
            clk_s <= {clk_s[1:0], pixel_clk};
            xfr_s <= {xfr_s[1:0], transfer_start_strobe};
            evn_s <= '{even_channel_bus, evn_s[0], evn_s[1]};
            odd_s <= '{odd_channel_bus, odd_s[0], odd_s[1]};
        end
    end

    // control and status state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic              ovf_reg;
    logic              ovf_next;
    logic [15:0]       xcnt_reg;
    logic [15:0]       xcnt_next;

    // loading sequence state
    logic       pend_reg;
    logic       pend_next;
    logic [3:0] pos_reg;
    logic [3:0] pos_next;
    logic [3:0] pos_eff;
    logic [3:0] ch;
    logic       rise;
    logic       fall;
    logic       start;
    logic       active;
    logic       dual;
    logic       dir;
    entry_t     push_e;

    always_comb begin
        rise      = clk_s[1] & ~clk_s[2];
        fall      = ~clk_s[1] & clk_s[2];
        dual      = ctrl_reg[BIT_DUAL];
        dir       = ctrl_reg[BIT_DIR];
        start     = rise && pend_reg;
        pend_next = rise ? xfr_s[2] : pend_reg;
        pos_eff   = start ? 4'h0 : pos_reg;
        active    = pos_eff < SEQ_DONE;
        pos_next  = pos_eff;
        ch        = dir ? LAST_CH - pos_eff : pos_eff;
        push_e    = '0;
        push_e.xfer = start;
        if (active && dual && rise) begin
            push_e.nwords = 2'd2;
            push_e.idx    = dir ? LAST_PAIR - pos_eff : pos_eff;
            push_e.w0     = evn_s[2];
            push_e.w1     = odd_s[2];
            pos_next      = pos_eff + 4'h2;
        end else if (active && !dual &&
                     ((rise && !pos_eff[0]) || (fall && pos_eff[0]))) begin
            // channel parity picks the bus, giving the direction edge swap
            push_e.nwords = 2'd1;
            push_e.idx    = ch;
            push_e.w0     = ch[0] ? odd_s[2] : evn_s[2];
            pos_next      = pos_eff + 4'h1;
        end
        q.push_valid = start || (push_e.nwords != 2'd0);
        q.push_data  = push_e;
        xcnt_next    = start ? xcnt_reg + 16'h0001 : xcnt_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 1'b0;
            pos_reg  <= SEQ_DONE;
            xcnt_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            pos_reg  <= pos_next;
            xcnt_reg <= xcnt_next;
        end
    end

    // latches and output stage, fed from the fifo
    logic [WORD_W-1:0] latch_reg  [NUM_CH];
    logic [WORD_W-1:0] latch_next [NUM_CH];
    logic [WORD_W-1:0] out_reg    [NUM_CH];
    logic [WORD_W-1:0] out_next   [NUM_CH];
    logic [WORD_W-1:0] offs_reg   [NUM_CH];
    logic [WORD_W-1:0] offs_next  [NUM_CH];
    logic [NUM_CH-1:0] above_reg;
    logic [NUM_CH-1:0] above_next;
    logic              gnd_reg;
    logic              therm_reg;
    entry_t            pop_e;

    // hold stalls draining so software can exercise back-pressure
    assign q.pop_ready = ~ctrl_reg[BIT_HOLD];

    always_comb begin
        pop_e      = entry_t'(q.pop_data);
        latch_next = latch_reg;
        out_next   = out_reg;
        if (q.pop_valid && q.pop_ready) begin
            if (pop_e.xfer) begin
                out_next = latch_reg;
            end
            if (pop_e.nwords != 2'd0) begin
                latch_next[pop_e.idx] = pop_e.w0;
            end
            if (pop_e.nwords == 2'd2) begin
                latch_next[pop_e.idx + 4'h1] = pop_e.w1;
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            offs_next[i]  = CODE_MAX - out_next[i];
            above_next[i] = ctrl_reg[BIT_ALT] ?
                            ctrl_reg[BIT_POL] ^ i[0] :
                            ctrl_reg[BIT_POL];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= '{default: '0};
            out_reg   <= '{default: '0};
            offs_reg  <= '{default: CODE_MAX};
            above_reg <= '0;
            gnd_reg   <= 1'b1;
            therm_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            out_reg   <= out_next;
            offs_reg  <= offs_next;
            above_reg <= above_next;
            gnd_reg   <= ~ctrl_reg[BIT_GND_N];
            therm_reg <= ctrl_reg[BIT_THERM];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_out
            assign analog_channel_out[g*WORD_W +: WORD_W] = out_reg[g];
            assign channel_offset[g*WORD_W +: WORD_W]     = offs_reg[g];
        end
    endgenerate
    assign above_center       = above_reg;
    assign outputs_grounded   = gnd_reg;
    assign thermal_protect_on = therm_reg;

    // apb slave: zero wait, read data prepared in the setup cycle
    logic        setup;
    logic        wr_acc;
    logic [31:0] rdata_next;
    logic        err_next;
    logic [31:0] rdata_reg;
    logic        err_reg;
    logic        ready_reg;
    logic [3:0]  oidx;

    always_comb begin
        setup      = psel && !penable;
        wr_acc     = psel && penable && pwrite && ready_reg;
        oidx       = 4'((paddr - OUT_BASE) >> 2);
        rdata_next = rdata_reg;
        err_next   = err_reg;
        ctrl_next  = ctrl_reg;
        // a new overflow wins over a clear in the same cycle
        ovf_next   = ovf_reg;
        if (wr_acc && paddr == STATUS_OFS && pwdata[ST_OVF]) begin
            ovf_next = 1'b0;
        end
        if (q.push_valid && !q.push_ready) begin
            ovf_next = 1'b1;
        end
        if (wr_acc && paddr == CTRL_OFS) begin
            ctrl_next = pwdata[CTRL_W-1:0];
        end
        if (setup) begin
            err_next   = 1'b0;
            rdata_next = '0;
            if (paddr == CTRL_OFS) begin
                rdata_next[CTRL_W-1:0] = ctrl_reg;
            end else if (paddr == STATUS_OFS) begin
                rdata_next[ST_POS +: 4]      = pos_reg;
                rdata_next[ST_PEND]          = pend_reg;
                rdata_next[ST_OVF]           = ovf_reg;
                rdata_next[ST_LEVEL +: CNT_W] = q.level;
                rdata_next[ST_XCNT +: 16]    = xcnt_reg;
            end else if (paddr >= OUT_BASE && paddr <= OUT_LAST &&
                         paddr[1:0] == 2'b00) begin
                rdata_next[WORD_W-1:0] = out_reg[oidx];
            end else begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= CTRL_RESET;
            ovf_reg   <= 1'b0;
            rdata_reg <= '0;
            err_reg   <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            ovf_reg   <= ovf_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
            ready_reg <= 1'b1;
        end
    end

    assign prdata  = rdata_reg;
    assign pready  = ready_reg;
    assign pslverr = err_reg;

    // checks on the loading and output logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_strobe_valid: assert property (
        rise && xfr_s[2] |=> pend_reg)
        else $error("valid strobe not remembered");
    a_seq_restart: assert property (
        start |=> pos_reg <= 4'h2)
        else $error("sequence did not restart after strobe");
    a_xfer_entry: assert property (
        start |-> q.push_valid && push_e.xfer)
        else $error("transfer not queued on start edge");
    a_seq_bound: assert property (
        pos_reg <= SEQ_DONE)
        else $error("sequence position past last channel");
    a_dual_edges: assert property (
        dual && fall && !start |-> !q.push_valid)
        else $error("dual bus captured on falling edge");
    a_single_edge: assert property (
        push_e.nwords == 2'd1 |-> rise == (push_e.idx[0] == dir))
        else $error("single bus word on wrong edge");
    a_first_channel: assert property (
        pos_eff == 4'h0 && push_e.nwords != 2'd0 |->
        push_e.idx == (dir ? (dual ? LAST_PAIR : LAST_CH) : 4'h0))
        else $error("sequence began at wrong channel");
    a_filled_idle: assert property (
        pos_reg == SEQ_DONE && !start |-> !q.push_valid)
        else $error("data taken after all channels filled");
    a_column_alt: assert property (
        ctrl_reg[BIT_ALT] && ctrl_reg[BIT_POL] && $stable(ctrl_reg)
        |=> above_reg == 12'h555)
        else $error("alternating polarity pattern wrong");
    a_offset_sum: assert property (
        offs_reg[0] + out_reg[0] == CODE_MAX)
        else $error("offset does not track code");
    a_ground_force: assert property (
        !ctrl_reg[BIT_GND_N] |=> outputs_grounded)
        else $error("outputs not grounded");
endmodule

// *** src/loader_pkg.sv ***
// constants, register map and types shared by the column loader
package loader_pkg;
    localparam int NUM_CH       = 12;
    localparam int WORD_W       = 12;
    localparam int FIFO_DEPTH   = 16;
    localparam int CNT_W        = 5;

    // sequence position meaning "all channels filled"
    localparam logic [3:0]  SEQ_DONE    = 4'hC;
    localparam logic [3:0]  LAST_CH     = 4'hB;
    localparam logic [3:0]  LAST_PAIR   = 4'hA;
    localparam logic [11:0] CODE_MAX    = 12'hFFF;

    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] STATUS_OFS  = 12'h004;
    localparam logic [11:0] OUT_BASE    = 12'h040;
    localparam logic [11:0] OUT_LAST    = 12'h06C;

    // control register fields
    localparam int BIT_DUAL   = 0;
    localparam int BIT_DIR    = 1;
    localparam int BIT_ALT    = 2;
    localparam int BIT_POL    = 3;
    localparam int BIT_GND_N  = 4;
    localparam int BIT_THERM  = 5;
    localparam int BIT_HOLD   = 6;
    localparam int CTRL_W     = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // status register fields
    localparam int ST_POS     = 0;
    localparam int ST_PEND    = 4;
    localparam int ST_OVF     = 5;
    localparam int ST_LEVEL   = 6;
    localparam int ST_XCNT    = 16;

    typedef struct packed {
        logic        xfer;
        logic [1:0]  nwords;
        logic [3:0]  idx;
        logic [11:0] w0;
        logic [11:0] w1;
    } entry_t;

    localparam int ENTRY_W = $bits(entry_t);
endpackage

// *** src/word_fifo_if.sv ***
// push and pop handshake between loader and its word fifo
`timescale 1ns/10ps
interface word_fifo_if #(parameter int W = 31, parameter int CW = 5);
    logic          push_valid;
    logic          push_ready;
    logic [W-1:0]  push_data;
    logic          pop_valid;
    logic          pop_ready;
    logic [W-1:0]  pop_data;
    logic [CW-1:0] level;

    modport store (input  push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, level);
    modport user  (output push_valid, push_data, pop_ready,
                   input  push_ready, pop_valid, pop_data, level);
endinterface

// *** src/word_fifo.sv ***
// synchronous fifo buffering captured words ahead of the latches
`timescale 1ns/10ps
module word_fifo
    import loader_pkg::*;
#(
    parameter int WIDTH = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // both handshakes
    word_fifo_if.store  q
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_reg;
    logic [AW:0]      rd_next;
    logic [AW:0]      used;
    logic             do_push;
    logic             do_pop;

    always_comb begin
        used         = wr_reg - rd_reg;
        q.push_ready = (used != DEPTH[AW:0]);
        q.pop_valid  = (used != '0);
        q.pop_data   = mem[rd_reg[AW-1:0]];
        q.level      = used;
        do_push      = q.push_valid && q.push_ready;
        do_pop       = q.pop_valid && q.pop_ready;
        wr_next      = do_push ? wr_reg + 1'b1 : wr_reg;
        rd_next      = do_pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage needs no reset; only words below the write pointer are read
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_reg[AW-1:0]] <= q.push_data;
        end
    end

    a_no_overrun: assert property (@(posedge pclk) disable iff (!presetn)
        used <= DEPTH[AW:0])
        else $error("fifo occupancy above depth");
endmodule

// *** tb/timing_ctrl_model.sv ***
// behavioural display timing controller driving the pixel link pins
`timescale 1ns/10ps
module timing_ctrl_model
    import loader_pkg::*;
(
    // system clock, paces the link
    input  wire logic           pclk,
    // pixel link pins
    output logic                pixel_clk,
    output logic                transfer_start_strobe,
    output logic [WORD_W-1:0]   even_channel_bus,
    output logic [WORD_W-1:0]   odd_channel_bus
);
    initial begin
        pixel_clk = 1'b0;
        transfer_start_strobe = 1'b0;
        even_channel_bus = 12'h000;
        odd_channel_bus = 12'hFFF;
    end

    // half a pixel period: pins set 3 pclk ahead of the edge, held 4 after
    task automatic half(input logic lvl, input logic [11:0] e, o,
                        input logic s);
        @(posedge pclk);
        even_channel_bus <= e;
        odd_channel_bus <= o;
        transfer_start_strobe <= s;
        repeat (3) @(posedge pclk);
        pixel_clk <= lvl;
        repeat (3) @(posedge pclk);
    endtask

    // fake puts the strobe around the falling edge only
    task automatic frame(input logic dual, dir, fake,
                         input logic [11:0] w [12]);
        logic [11:0] j;
        int a;
        logic sp;
        j = ~w[0];
        half(1'b1, j, ~j, ~fake);
        half(1'b0, ~j, j, fake);
        for (int k = 0; k < 7; k++) begin
            a = dir ? 10 - 2 * k : 2 * k;
            sp = (k == 6);
            if (sp) begin
                a = 0;
            end
            half(1'b1, (!sp && (dual || !dir)) ? w[a] : j,
                 (!sp && (dual || dir)) ? w[a+1] : ~j, 1'b0);
            half(1'b0, (!sp && !dual && dir) ? w[a] : ~j,
                 (!sp && !dual && !dir) ? w[a+1] : j, 1'b0);
        end
        // released link: buses show the inverse, clock stands low
        @(posedge pclk);
        even_channel_bus <= ~even_channel_bus;
        odd_channel_bus <= ~odd_channel_bus;
    endtask
endmodule

// *** tb/column_driver_input_loader_tb.sv ***
// self-checking bench for the column driver input loader
`timescale 1ns/10ps
module column_driver_input_loader_tb
    import loader_pkg::*;
;
    typedef struct packed {
        logic [6:0]  ctrl;
        logic [11:0] base;
    } row_t;

    logic                     pclk;
    logic                     presetn;
    logic [11:0]              paddr;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     pixel_clk;
    logic                     transfer_start_strobe;
    logic [WORD_W-1:0]        even_channel_bus;
    logic [WORD_W-1:0]        odd_channel_bus;
    logic [NUM_CH*WORD_W-1:0] analog_channel_out;
    logic [NUM_CH*WORD_W-1:0] channel_offset;
    logic [NUM_CH-1:0]        above_center;
    logic                     outputs_grounded;
    logic                     thermal_protect_on;
    logic [11:0]              w [12];
    int                       bad_count = 0;
    int                       comparisons = 0;
    // dual, direction, alternation and polarity spread over rows
    row_t rows [6] = '{'{7'h11, 12'h000}, '{7'h1B, 12'h123},
                       '{7'h34, 12'h456}, '{7'h3E, 12'hFFF},
                       '{7'h17, 12'h789}, '{7'h3C, 12'hABC}};

    column_driver_input_loader i_column_driver_input_loader (.*);
    timing_ctrl_model i_timing_ctrl_model (.*);

    always #50 pclk = ~pclk;

    task automatic chk(input string nm, input logic [143:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fill(input logic [11:0] b);
        for (int i = 0; i < 12; i++) w[i] = b + 12'(i * 341);
    endtask

    task automatic send(input logic [6:0] c, input logic fake);
        i_timing_ctrl_model.frame(c[BIT_DUAL], c[BIT_DIR], fake, w);
    endtask

    task automatic check_out(input logic [6:0] c);
        logic [31:0] rd;
        logic        er;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 12; i++) begin
            chk("code", w[i], analog_channel_out[12*i +: 12]);
            chk("offset", CODE_MAX - w[i], channel_offset[12*i +: 12]);
            chk("above", (c[BIT_ALT] && i[0]) ^ c[BIT_POL], above_center[i]);
            apb(1'b0, OUT_BASE + 12'(4 * i), 32'h0, rd, er);
            chk("out_reg", w[i], rd);
        end
        chk("grounded", !c[BIT_GND_N], outputs_grounded);
        chk("thermal", c[BIT_THERM], thermal_protect_on);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] rd;
        logic        er;
        int          n;
        pclk = 1'b0;
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        chk("grounded_rst", 1'b1, outputs_grounded);
        chk("thermal_rst", 1'b0, thermal_protect_on);
        chk("offset_rst", {NUM_CH{CODE_MAX}}, channel_offset);
        chk("pready_rst", 1'b0, pready);
        presetn <= 1'b1;
        apb(1'b0, STATUS_OFS, 32'h0, rd, er);
        chk("status_rst", 32'h0000000C, rd);
        apb(1'b0, CTRL_OFS, 32'h0, rd, er);
        chk("ctrl_rst", 32'h0, rd);
        foreach (rows[r]) begin
            apb(1'b1, CTRL_OFS, {25'h0, rows[r].ctrl}, rd, er);
            apb(1'b0, CTRL_OFS, 32'h0, rd, er);
            chk("ctrl", {25'h0, rows[r].ctrl}, rd);
            fill(rows[r].base);
            send(rows[r].ctrl, 1'b0);
            send(rows[r].ctrl, 1'b0);
            check_out(rows[r].ctrl);
            apb(1'b0, STATUS_OFS, 32'h0, rd, er);
            chk("position", 4'hC, rd[3:0]);
        end
        chk("xfer_count", 16'd12, rd[31:16]);
        // held drain lets the fifo fill and overflow
        apb(1'b1, CTRL_OFS, 32'h51, rd, er);
        repeat (3) send(7'h11, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0, rd, er);
        chk("fifo_full", 5'h10, rd[ST_LEVEL +: 5]);
        chk("overflow", 1'b1, rd[ST_OVF]);
        apb(1'b1, CTRL_OFS, 32'h11, rd, er);
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0, rd, er);
            n++;
        end while (rd[ST_LEVEL +: 5] !== 5'h00 && n < 50);
        chk("fifo_empty", 5'h00, rd[ST_LEVEL +: 5]);
        apb(1'b1, STATUS_OFS, 32'h20, rd, er);
        apb(1'b0, STATUS_OFS, 32'h0, rd, er);
        chk("ovf_clear", 1'b0, rd[ST_OVF]);
        // strobe only around a falling edge must not transfer
        fill(12'h321);
        send(7'h11, 1'b0);
        fill(12'h654);
        send(7'h11, 1'b0);
        fill(12'h321);
        check_out(7'h11);
        fill(12'hBCD);
        send(7'h11, 1'b1);
        fill(12'h321);
        check_out(7'h11);
        fill(12'h0F0);
        send(7'h11, 1'b0);
        fill(12'h654);
        check_out(7'h11);
        apb(1'b1, CTRL_OFS, 32'h20, rd, er);
        repeat (4) @(posedge pclk);
        chk("ground_force", 1'b1, outputs_grounded);
        chk("thermal_on", 1'b1, thermal_protect_on);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        chk("unmapped_err", 1'b1, er);
        chk("unmapped_data", 32'h0, rd);
        apb(1'b0, 12'h070, 32'h0, rd, er);
        chk("past_out_err", 1'b1, er);
        apb(1'b1, 12'h002, 32'h7F, rd, er);
        chk("unaligned_err", 1'b1, er);
        apb(1'b0, CTRL_OFS, 32'h0, rd, er);
        chk("ctrl_kept", 32'h20, rd);
        tally_and_finish();
    end
endmodule
